// ---- rtl/drive_supervisor_map.svh ----
`ifndef DRIVE_SUPERVISOR_MAP_SVH
`define DRIVE_SUPERVISOR_MAP_SVH

// -----------------------------------------------------------------------------
// Register byte offsets on the Avalon-MM bus.
// -----------------------------------------------------------------------------
`define OFS_CONTROL     4'h0
`define OFS_FAULT_RESET 4'h4
`define OFS_FAULT_SET   4'h8
`define OFS_STATUS      4'hC

// -----------------------------------------------------------------------------
// Field positions and values.
// -----------------------------------------------------------------------------
`define CW_RESET_BIT    7
`define FAULT_RESET_DEF 32'h0000_0000
`define FAULT_RESET_GO  32'h0000_0001
`define STOP_TIME_NS    1000
`define CLK_PERIOD_NS   10
`define STOP_CYCLES     ((`STOP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- rtl/drive_supervisor_pkg.sv ----
package drive_supervisor_pkg;

  // Drive-profile operating states.
  typedef enum logic [2:0] {
    ST_INIT,
    ST_NO_FAULT,
    ST_READY,
    ST_WAIT_SON,
    ST_RUNNING,
    ST_QUICK_STOP,
    ST_STOP_FAULT,
    ST_FAULT
  } drive_state_t;

  // Severity of the worst pending condition.
  typedef enum logic [1:0] {
    SEV_NONE,
    SEV_ONE,
    SEV_TWO,
    SEV_THREE
  } severity_t;

endpackage : drive_supervisor_pkg

// ---- rtl/reset_edge_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// Carries the control word and the reset pulse between the supervisor and
// its edge detector.
interface reset_edge_if;
  logic        cw_valid;
  logic [15:0] cw_word;
  logic        reset_pulse;

  modport owner  (output cw_valid, output cw_word, input reset_pulse);
  modport detect (input cw_valid, input cw_word, output reset_pulse);
endinterface : reset_edge_if

`default_nettype wire

// ---- rtl/reset_edge_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "drive_supervisor_map.svh"

module reset_edge_detect (
  // Clock and reset.
  input  wire logic   clk_sys,
  input  wire logic   nrst,
  input  wire logic   clk_en,
  // Control word side.
  reset_edge_if.detect re
);

  typedef struct packed {
    logic prev_bit;
    logic pulse;
  } edge_state_t;

  edge_state_t st_reg;
  edge_state_t st_next;

  // Bit 7 is compared with its value from the previous control-word update,
  // so a steady high level never repeats the reset.
  always_comb begin
    st_next       = st_reg;
    st_next.pulse = 1'b0;
    if (re.cw_valid) begin
      st_next.prev_bit = re.cw_word[`CW_RESET_BIT];
      st_next.pulse    = re.cw_word[`CW_RESET_BIT] & ~st_reg.prev_bit;
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign re.reset_pulse = st_reg.pulse & clk_en;

endmodule : reset_edge_detect

`default_nettype wire

// ---- rtl/drive_state_fault_supervisor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "drive_supervisor_map.svh"

// What this block does
// - Initialization state rejects all parameter writes and runs nothing.
// - No-fault state is held when nothing is pending or after clearing.
// - No-fault, ready and waiting states accept every parameter write.
// - Running keeps a mode enabled, motor energized; motion when speed nonzero.
// - Running, quick stop, stop at fault accept only run-changeable writes.
// - Quick stop request enters quick stop until deceleration ends.
// - Fault while operating enters stop-at-fault and stops the motor.
// - After fault stop, fault state blocks functions, allows parameter writes.
// - Three severity levels; level three warns, one and two fault.
// - Non-resettable level-one faults exist beside resettable ones.
// - A valid reset clears every resettable fault or warning.
// - Writing 1 to the fault-reset parameter requests a reset.
// - Rising edge of control word bit 7 requests a reset.
// - Level-three warning clears itself when its cause disappears.
// - Fault-reset parameter returns to 0 right after acting.
// - Fault-reset defaults 0, writable only stopped, effective immediately.
// - Ready once control initialized and main power; run needs servo enable.
module drive_state_fault_supervisor #(
  parameter int STOP_CYCLES = `STOP_CYCLES
) (
  // Clock, reset and enable.
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // Avalon-MM register slave.
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  // Drive conditions from the power and control sections.
  input  wire logic        selfcheck_done,
  input  wire logic        main_power_ok,
  input  wire logic        warn_cond,
  input  wire logic        speed_nonzero,
  // Host parameter write gate.
  input  wire logic        param_wr_req,
  input  wire logic        param_run_ok,
  output logic             param_wr_accept,
  output logic             param_wr_reject,
  // Drive outputs.
  output logic             motor_energize,
  output logic             mode_enable,
  output logic             motion_allow,
  output logic             func_allow
);

  // ---------------------------------------------------------------------------
  // Elaboration checks.
  // ---------------------------------------------------------------------------
  if (STOP_CYCLES < 1 || STOP_CYCLES > 65535) begin : g_bad_stop
    $error("STOP_CYCLES out of range");
  end

  // ---------------------------------------------------------------------------
  // State record.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    drive_supervisor_pkg::drive_state_t state;
    logic [15:0]                        control;
    logic                               fault_reset;
    logic                               fault_nr;
    logic                               fault_l1;
    logic                               fault_l2;
    logic                               warn_l3;
    logic [15:0]                        stop_cnt;
    logic                               sc_meta;
    logic                               sc_sync;
    logic                               mp_meta;
    logic                               mp_sync;
    logic                               wc_meta;
    logic                               wc_sync;
    logic                               sp_meta;
    logic                               sp_sync;
    logic [31:0]                        rdata;
    logic                               ack;
    logic [1:0]                         resp;
  } sup_state_t;

  sup_state_t s_reg;
  sup_state_t s_next;

  reset_edge_if re ();

  // Bit 7 edge detection lives in its own module.
  reset_edge_detect u_edge (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clk_en  (clk_en),
    .re      (re.detect)
  );

  // Control-word bit assignments within the control register.
  localparam int CW_SON   = 0;
  localparam int CW_QSTOP = 2;

  // Fault-set register bit assignments.
  localparam int FS_NR = 0;
  localparam int FS_L1 = 1;
  localparam int FS_L2 = 2;

  // Returns the worst pending severity.
  function automatic drive_supervisor_pkg::severity_t worst_level(
    input logic nr, input logic l1, input logic l2, input logic l3);
    if (nr || l1) begin
      return drive_supervisor_pkg::SEV_ONE;
    end else if (l2) begin
      return drive_supervisor_pkg::SEV_TWO;
    end else if (l3) begin
      return drive_supervisor_pkg::SEV_THREE;
    end
    return drive_supervisor_pkg::SEV_NONE;
  endfunction : worst_level

  // ---------------------------------------------------------------------------
  // Decoded bus strobes and helpers.
  // ---------------------------------------------------------------------------
  logic wr_ctl;
  logic wr_rst;
  logic wr_fs;
  logic bus_req;
  logic stopped;
  logic fault_any;
  logic reset_req;
  logic rst_ok;

  always_comb begin
    bus_req   = (avs_read | avs_write) & ~s_reg.ack;
    wr_ctl    = avs_write & s_reg.ack & (avs_address == `OFS_CONTROL) & avs_byteenable[0];
    wr_rst    = avs_write & s_reg.ack & (avs_address == `OFS_FAULT_RESET) & avs_byteenable[0];
    wr_fs     = avs_write & s_reg.ack & (avs_address == `OFS_FAULT_SET) & avs_byteenable[0];
    stopped   = (s_reg.state != drive_supervisor_pkg::ST_RUNNING) &&
                (s_reg.state != drive_supervisor_pkg::ST_QUICK_STOP) &&
                (s_reg.state != drive_supervisor_pkg::ST_STOP_FAULT);
    fault_any = s_reg.fault_nr | s_reg.fault_l1 | s_reg.fault_l2;
    // The parameter form only counts while the drive is stopped.
    reset_req = re.reset_pulse | s_reg.fault_reset;
    // Level one and two clear only with servo enable dropped.
    rst_ok    = reset_req & ~s_reg.control[CW_SON];
  end

  assign re.cw_valid = wr_ctl & clk_en;
  assign re.cw_word  = avs_writedata[15:0];

  // ---------------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // Two-stage synchronisers for the pin inputs.
    s_next.sc_meta = selfcheck_done;
    s_next.sc_sync = s_reg.sc_meta;
    s_next.mp_meta = main_power_ok;
    s_next.mp_sync = s_reg.mp_meta;
    s_next.wc_meta = warn_cond;
    s_next.wc_sync = s_reg.wc_meta;
    s_next.sp_meta = speed_nonzero;
    s_next.sp_sync = s_reg.sp_meta;

    // Fault-reset parameter self-clears one cycle after acting.
    s_next.fault_reset = 1'b0;
    if (wr_rst && stopped && avs_writedata == `FAULT_RESET_GO) begin
      s_next.fault_reset = 1'b1;
    end
    if (wr_ctl) begin
      s_next.control = avs_writedata[15:0];
    end

    // Resettable faults clear on a reset; new sets win over the clear.
    if (rst_ok) begin
      s_next.fault_l1 = 1'b0;
      s_next.fault_l2 = 1'b0;
    end
    if (wr_fs) begin
      s_next.fault_nr = s_reg.fault_nr | avs_writedata[FS_NR];
      s_next.fault_l1 = s_next.fault_l1 | avs_writedata[FS_L1];
      s_next.fault_l2 = s_next.fault_l2 | avs_writedata[FS_L2];
    end
    // Warning follows its cause; a reset clears it for one cycle, and it sets again while the cause remains.
    if (!s_reg.wc_sync) begin
      s_next.warn_l3 = 1'b0;
    end else if (!s_reg.warn_l3 && !reset_req) begin
      s_next.warn_l3 = 1'b1;
    end
    if (reset_req) begin
      s_next.warn_l3 = 1'b0;
    end

    if (s_reg.stop_cnt != 16'h0000) begin
      s_next.stop_cnt = s_reg.stop_cnt - 16'h0001;
    end

    // Operating state machine, driven by the host's control word.
    unique case (s_reg.state)
      drive_supervisor_pkg::ST_INIT: begin
        if (s_reg.sc_sync) begin
          s_next.state = fault_any ? drive_supervisor_pkg::ST_FAULT
                                   : drive_supervisor_pkg::ST_NO_FAULT;
        end
      end
      drive_supervisor_pkg::ST_NO_FAULT: begin
        if (fault_any) begin
          s_next.state = drive_supervisor_pkg::ST_FAULT;
        end else if (s_reg.mp_sync) begin
          s_next.state = drive_supervisor_pkg::ST_READY;
        end
      end
      drive_supervisor_pkg::ST_READY: begin
        if (fault_any) begin
          s_next.state = drive_supervisor_pkg::ST_FAULT;
        end else if (!s_reg.mp_sync) begin
          s_next.state = drive_supervisor_pkg::ST_NO_FAULT;
        end else begin
          s_next.state = drive_supervisor_pkg::ST_WAIT_SON;
        end
      end
      drive_supervisor_pkg::ST_WAIT_SON: begin
        if (fault_any) begin
          s_next.state = drive_supervisor_pkg::ST_FAULT;
        end else if (!s_reg.mp_sync) begin
          s_next.state = drive_supervisor_pkg::ST_NO_FAULT;
        end else if (s_reg.control[CW_SON]) begin
          s_next.state = drive_supervisor_pkg::ST_RUNNING;
        end
      end
      drive_supervisor_pkg::ST_RUNNING: begin
        if (fault_any) begin
          s_next.state    = drive_supervisor_pkg::ST_STOP_FAULT;
          s_next.stop_cnt = 16'(STOP_CYCLES);
        end else if (s_reg.control[CW_QSTOP]) begin
          s_next.state    = drive_supervisor_pkg::ST_QUICK_STOP;
          s_next.stop_cnt = 16'(STOP_CYCLES);
        end else if (!s_reg.control[CW_SON]) begin
          s_next.state = drive_supervisor_pkg::ST_WAIT_SON;
        end
      end
      drive_supervisor_pkg::ST_QUICK_STOP: begin
        if (fault_any) begin
          s_next.state    = drive_supervisor_pkg::ST_STOP_FAULT;
          s_next.stop_cnt = 16'(STOP_CYCLES);
        end else if (s_reg.stop_cnt == 16'h0000) begin
          s_next.state = drive_supervisor_pkg::ST_WAIT_SON;
        end
      end
      drive_supervisor_pkg::ST_STOP_FAULT: begin
        if (s_reg.stop_cnt == 16'h0000) begin
          s_next.state = drive_supervisor_pkg::ST_FAULT;
        end
      end
      drive_supervisor_pkg::ST_FAULT: begin
        // Non-resettable faults pin the state here.
        if (!s_reg.fault_nr && rst_ok &&
            !s_next.fault_l1 && !s_next.fault_l2) begin
          s_next.state = drive_supervisor_pkg::ST_NO_FAULT;
        end
      end
    endcase

    // Avalon answer: one wait cycle, then data from the register.
    s_next.ack  = bus_req;
    s_next.resp = 2'b00;
    s_next.rdata = 32'h0000_0000;
    if (bus_req) begin
      unique case (avs_address)
        `OFS_CONTROL:     s_next.rdata = {16'h0000, s_reg.control};
        `OFS_FAULT_RESET: s_next.rdata = {31'h0, s_reg.fault_reset};
        `OFS_FAULT_SET:   s_next.rdata = {29'h0, s_reg.fault_l2, s_reg.fault_l1,
                                          s_reg.fault_nr};
        `OFS_STATUS:      s_next.rdata = {24'h0, 1'b0, s_reg.warn_l3,
                                          worst_level(s_reg.fault_nr, s_reg.fault_l1,
                                                      s_reg.fault_l2, s_reg.warn_l3),
                                          1'b0, s_reg.state};
        default:          s_next.resp  = 2'b10;
      endcase
    end else begin
      s_next.rdata = s_reg.rdata;
    end
  end

  // Register the whole state record.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg       <= '0;
      s_reg.state <= drive_supervisor_pkg::ST_INIT;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------------------
  // The bus stalls while the clock enable is low so no access is lost.
  assign avs_waitrequest = (avs_read | avs_write) & ~(s_reg.ack & clk_en);
  assign avs_readdata    = s_reg.rdata;
  assign avs_response    = s_reg.resp;

  // Parameter gate per state; the fault state still accepts for diagnosis.
  always_comb begin
    param_wr_accept = 1'b0;
    unique case (s_reg.state)
      drive_supervisor_pkg::ST_INIT:       param_wr_accept = 1'b0;
      drive_supervisor_pkg::ST_NO_FAULT,
      drive_supervisor_pkg::ST_READY,
      drive_supervisor_pkg::ST_WAIT_SON:   param_wr_accept = param_wr_req;
      drive_supervisor_pkg::ST_RUNNING,
      drive_supervisor_pkg::ST_QUICK_STOP,
      drive_supervisor_pkg::ST_STOP_FAULT: param_wr_accept = param_wr_req & param_run_ok;
      drive_supervisor_pkg::ST_FAULT:      param_wr_accept = param_wr_req;
    endcase
    param_wr_reject = param_wr_req & ~param_wr_accept;
  end

  // Drive power and function enables.
  always_comb begin
    motor_energize = (s_reg.state == drive_supervisor_pkg::ST_RUNNING) ||
                     (s_reg.state == drive_supervisor_pkg::ST_QUICK_STOP) ||
                     (s_reg.state == drive_supervisor_pkg::ST_STOP_FAULT);
    mode_enable    = (s_reg.state == drive_supervisor_pkg::ST_RUNNING);
    motion_allow   = mode_enable & s_reg.sp_sync;
    func_allow     = (s_reg.state != drive_supervisor_pkg::ST_INIT) &&
                     (s_reg.state != drive_supervisor_pkg::ST_FAULT);
  end

endmodule : drive_state_fault_supervisor

`default_nettype wire

// ---- tb/drive_state_fault_supervisor_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "drive_supervisor_map.svh"

// ---------------------------------------------------------------
// Port-level checker for the drive supervisor
// ---------------------------------------------------------------
module drive_state_fault_supervisor_sva #(
  parameter int STOP_CYCLES = 100
) (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        clk_en,
  // Register bus.
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  // Drive conditions and outputs.
  input wire logic        selfcheck_done,
  input wire logic        main_power_ok,
  input wire logic        speed_nonzero,
  input wire logic        param_wr_req,
  input wire logic        param_run_ok,
  input wire logic        param_wr_accept,
  input wire logic        param_wr_reject,
  input wire logic        motor_energize,
  input wire logic        mode_enable,
  input wire logic        motion_allow,
  input wire logic        func_allow
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  logic       st_rd;
  logic [2:0] st;
  // A completing status read shows the state; only settled states are polled.
  assign st_rd = avs_read && avs_address == `OFS_STATUS && !avs_waitrequest;
  assign st    = avs_readdata[2:0];

  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en
    ##1 clk_en |-> !avs_waitrequest) else $error("bus answer late");
  AST_UNMAPPED: assert property (avs_read && !avs_waitrequest
    && !(avs_address inside {4'h0, 4'h4, 4'h8, 4'hC}) |-> avs_response == 2'h2)
    else $error("unmapped read not flagged");
  AST_INIT_GATE: assert property ((!selfcheck_done)[*3] ##0 param_wr_req |->
    param_wr_reject && !param_wr_accept && !func_allow) else $error("init gate open");
  AST_IDLE_WR: assert property (st_rd && st inside {3'h1, 3'h2, 3'h3} && param_wr_req
    |-> param_wr_accept && !param_wr_reject) else $error("idle write refused");
  AST_RUN_OUT: assert property (st_rd && st == 3'h4 |->
    motor_energize && mode_enable) else $error("running without drive");
  AST_MOTION: assert property (motion_allow |-> motor_energize && mode_enable)
    else $error("motion without drive");
  AST_STILL: assert property ((!speed_nonzero)[*4] |-> !motion_allow)
    else $error("motion at zero speed");
  AST_RUN_WR: assert property (st_rd && st inside {3'h4, 3'h5, 3'h6} && param_wr_req
    |-> param_wr_accept == param_run_ok && param_wr_reject == !param_run_ok)
    else $error("run write gate wrong");
  AST_FAULT_OUT: assert property (st_rd && st == 3'h7 |-> !func_allow
    && (param_wr_accept || !param_wr_req)) else $error("fault gate wrong");
  AST_POWER: assert property ((!main_power_ok)[*4] |-> !motor_energize)
    else $error("energized without power");

  cover property (motion_allow);
  cover property (st_rd && st == 3'h7);
  cover property (param_wr_reject && motor_energize);
endmodule : drive_state_fault_supervisor_sva

bind drive_state_fault_supervisor drive_state_fault_supervisor_sva #(
  .STOP_CYCLES(STOP_CYCLES)
) u_sva (
  .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .selfcheck_done(selfcheck_done), .main_power_ok(main_power_ok),
  .speed_nonzero(speed_nonzero), .param_wr_req(param_wr_req),
  .param_run_ok(param_run_ok), .param_wr_accept(param_wr_accept),
  .param_wr_reject(param_wr_reject), .motor_energize(motor_energize),
  .mode_enable(mode_enable), .motion_allow(motion_allow), .func_allow(func_allow)
);

`default_nettype wire

// ---- tb/drive_plant_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Power and control section seen by the supervisor
// ---------------------------------------------------------------
module drive_plant_model (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Commands from the bench.
  input  wire logic power_cmd,
  input  wire logic warn_src,
  input  wire logic speed_src,
  // Condition lines.
  output logic      selfcheck_done,
  output logic      main_power_ok,
  output logic      warn_cond,
  output logic      speed_nonzero
);
  logic [4:0] boot_cnt;
  // Self-check takes a while so that the init state can be observed first.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      boot_cnt <= 5'h00;
    end else if (boot_cnt != 5'h1F) begin
      boot_cnt <= boot_cnt + 5'h01;
    end
  end
  // Main power can only be present once the control circuit is up.
  assign selfcheck_done = (boot_cnt == 5'h1F);
  assign main_power_ok  = power_cmd && selfcheck_done;
  assign warn_cond      = warn_src;
  assign speed_nonzero  = speed_src;
endmodule : drive_plant_model

`default_nettype wire

// ---- tb/drive_state_fault_supervisor_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "drive_supervisor_map.svh"

// ---------------------------------------------------------------
// Self-checking bench driving the register bus and plant
// ---------------------------------------------------------------
module drive_state_fault_supervisor_tb_top;
  logic        clk_sys, nrst, clk_en, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0]  avs_response, rsp;
  logic        selfcheck_done, main_power_ok, warn_cond, speed_nonzero;
  logic        param_wr_req, param_run_ok, param_wr_accept, param_wr_reject;
  logic        motor_energize, mode_enable, motion_allow, func_allow;
  logic        power_cmd, warn_src, speed_src;
  int          err_total, n_checks;

  drive_state_fault_supervisor #(.STOP_CYCLES(20)) uut (
    .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .selfcheck_done(selfcheck_done), .main_power_ok(main_power_ok),
    .warn_cond(warn_cond), .speed_nonzero(speed_nonzero), .param_wr_req(param_wr_req),
    .param_run_ok(param_run_ok), .param_wr_accept(param_wr_accept),
    .param_wr_reject(param_wr_reject), .motor_energize(motor_energize),
    .mode_enable(mode_enable), .motion_allow(motion_allow), .func_allow(func_allow));

  drive_plant_model u_plant (
    .clk_sys(clk_sys), .nrst(nrst), .power_cmd(power_cmd), .warn_src(warn_src),
    .speed_src(speed_src), .selfcheck_done(selfcheck_done),
    .main_power_ok(main_power_ok), .warn_cond(warn_cond), .speed_nonzero(speed_nonzero));

  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // One bus access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd  = avs_readdata;
    rsp = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Polls status until a field lands in range; a bounded count avoids a hang.
  task automatic poll(input logic [31:0] mask, input logic [31:0] lo, input logic [31:0] hi);
    for (int i = 0; i < 40; i++) begin
      bus(1'b0, `OFS_STATUS, 32'h0);
      if ((rd & mask) >= lo && (rd & mask) <= hi) break;
    end
  endtask : poll

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // Main sequence: start-up, run, quick stop, warning and fault handling.
  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    param_wr_req = 1'b1;
    param_run_ok = 1'b0;
    power_cmd = 1'b0;
    warn_src = 1'b0;
    speed_src = 1'b0;
    err_total = 0;
    n_checks = 0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    bus(1'b0, `OFS_STATUS, 32'h0);
    check("init state", rd[2:0], 3'h0);
    check("init reject", param_wr_reject, 1'b1);
    bus(1'b0, `OFS_FAULT_RESET, 32'h0);
    check("reset param default", rd, `FAULT_RESET_DEF);
    bus(1'b0, 4'h2, 32'h0);
    check("unmapped response", rsp, 2'h2);
    power_cmd <= 1'b1;
    poll(32'h7, 32'h1, 32'h3);
    check("idle accept", param_wr_accept, 1'b1);
    bus(1'b1, `OFS_CONTROL, 32'h1);
    poll(32'h7, 32'h4, 32'h4);
    check("running", rd[2:0], 3'h4);
    check("energized", motor_energize && mode_enable, 1'b1);
    check("run reject", param_wr_reject, 1'b1);
    speed_src <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check("motion", motion_allow, 1'b1);
    speed_src <= 1'b0;
    param_run_ok <= 1'b1;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check("no motion", motion_allow, 1'b0);
    check("run accept", param_wr_accept, 1'b1);
    bus(1'b1, `OFS_CONTROL, 32'h5);
    poll(32'h7, 32'h5, 32'h5);
    check("quick stop", rd[2:0], 3'h5);
    bus(1'b1, `OFS_CONTROL, 32'h0);
    clk_en <= 1'b0;
    repeat (30) @(posedge clk_sys);
    clk_en <= 1'b1;
    bus(1'b0, `OFS_STATUS, 32'h0);
    check("quick stop holds", rd[2:0], 3'h5);
    poll(32'h7, 32'h1, 32'h3);
    check("quick stop done", rd[2:0] inside {3'h1, 3'h2, 3'h3}, 1'b1);
    warn_src <= 1'b1;
    poll(32'h40, 32'h40, 32'h40);
    check("warning level", rd[6:4], 3'h7);
    warn_src <= 1'b0;
    poll(32'h40, 32'h0, 32'h0);
    check("warning self clear", rd[6], 1'b0);
    bus(1'b1, `OFS_CONTROL, 32'h1);
    poll(32'h7, 32'h4, 32'h4);
    bus(1'b1, `OFS_FAULT_SET, 32'h4);
    poll(32'h7, 32'h6, 32'h6);
    check("stop at fault", rd[2:0], 3'h6);
    poll(32'h7, 32'h7, 32'h7);
    check("fault level two", rd[5:0], 6'h27);
    check("fault func", func_allow, 1'b0);
    bus(1'b1, `OFS_CONTROL, 32'h81);
    bus(1'b0, `OFS_STATUS, 32'h0);
    check("reset with servo on", rd[2:0], 3'h7);
    bus(1'b1, `OFS_CONTROL, 32'h0);
    bus(1'b1, `OFS_CONTROL, 32'h80);
    poll(32'h7, 32'h1, 32'h3);
    check("edge reset", rd[2:0] inside {3'h1, 3'h2, 3'h3}, 1'b1);
    bus(1'b1, `OFS_FAULT_SET, 32'h2);
    poll(32'h7, 32'h7, 32'h7);
    bus(1'b1, `OFS_CONTROL, 32'h80);
    bus(1'b0, `OFS_STATUS, 32'h0);
    check("steady bit no reset", rd[5:0], 6'h17);
    bus(1'b1, `OFS_FAULT_RESET, `FAULT_RESET_GO);
    poll(32'h7, 32'h1, 32'h3);
    check("param reset", rd[2:0] inside {3'h1, 3'h2, 3'h3}, 1'b1);
    bus(1'b0, `OFS_FAULT_RESET, 32'h0);
    check("param back to zero", rd, `FAULT_RESET_DEF);
    bus(1'b1, `OFS_FAULT_SET, 32'h1);
    poll(32'h7, 32'h7, 32'h7);
    bus(1'b1, `OFS_FAULT_RESET, `FAULT_RESET_GO);
    bus(1'b1, `OFS_CONTROL, 32'h0);
    bus(1'b1, `OFS_CONTROL, 32'h80);
    bus(1'b0, `OFS_STATUS, 32'h0);
    check("fixed fault stays", rd[5:0], 6'h17);
    conclude();
  end

  // Watchdog well beyond the longest expected run.
  initial begin
    #300000;
    err_total++;
    conclude();
  end
endmodule : drive_state_fault_supervisor_tb_top

`default_nettype wire
